/* rtl/clock_unit_pkg.sv */
// shared constants, register map and types of the clock select unit
package clock_unit_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_FLAG = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PLL = 8'h08;
  localparam logic [7:0] ADDR_MDIV = 8'h0c;
  localparam logic [7:0] ADDR_PDIV = 8'h10;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FLAG_PLL_SEL = 0;
  localparam int FLAG_LOCK = 1;
  localparam int FLAG_NOT_SLOW = 3;
  localparam int FLAG_DIV16_PEND = 4;
  localparam int FLAG_LOCK_PEND = 5;
  localparam int FLAG_STOP_PEND = 6;
  localparam int FLAG_ALT_PEND = 7;
  localparam int FLAG_HALVE = 15;
  localparam int CTRL_LOCK_IE = 0;
  localparam int CTRL_DIV16_IE = 1;
  localparam int CTRL_STOP_IE = 2;
  localparam int CTRL_ALT_SEL = 3;
  localparam int PLL_CFG_W = 7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] FLAG_RESET = 16'h8008;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PLL_RESET = 16'h001c;
  localparam logic [15:0] FACT_RESET = 16'h0000;

  // ****************************************************************
  // pll codes and figures
  // ****************************************************************
  localparam logic [1:0] MULT_CODE_24 = 2'h2;
  localparam logic [1:0] MULT_CODE_20 = 2'h0;
  localparam logic [1:0] MULT_CODE_16 = 2'h3;
  localparam logic [1:0] MULT_CODE_12 = 2'h1;
  localparam logic [4:0] MULT_24 = 5'h18;
  localparam logic [4:0] MULT_20 = 5'h14;
  localparam logic [4:0] MULT_16 = 5'h10;
  localparam logic [4:0] MULT_12 = 5'h0c;
  localparam logic [2:0] DIV_OFF_CODE = 3'h7;
  localparam logic [9:0] FREE_KHZ_125 = 10'h07d;
  localparam logic [9:0] FREE_KHZ_250 = 10'h0fa;
  localparam logic [9:0] FREE_KHZ_500 = 10'h1f4;
  localparam int LOCK_WINDOW_DEF = 32;
  localparam int LOCK_TOL = 2;
  localparam int LOCK_GOOD = 2;
  localparam logic [3:0] DIV16_LAST = 4'hf;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    SRC_INTERMEDIATE, SRC_DIV16, SRC_PLL, SRC_FREE_RUN, SRC_ALT
  } root_src_t;

  typedef enum logic [1:0] {PLL_OFF, PLL_LOOP, PLL_FREE} pll_mode_t;

  typedef struct packed {
    logic reference_range_bit;
    logic free_run_enable;
    logic [2:0] pll_divider_field;
    logic [1:0] pll_multiplier_field;
  } pll_cfg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

/* rtl/intermediate_divider.sv */
// optional halving of the oscillator strobe plus the divide-by-16 strobe
module intermediate_divider
  import clock_unit_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_tick_i,
  input wire logic halve_i,
  output logic intermediate_clock_tick_o,
  output logic div16_tick_o
);

  logic phase_reg;
  logic [3:0] cnt16_reg;
  wire intermediate_clock_next = osc_tick_i & (~halve_i | phase_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 1'b0;
      cnt16_reg <= 4'h0;
      intermediate_clock_tick_o <= 1'b0;
      div16_tick_o <= 1'b0;
    end else begin
      if (osc_tick_i) begin
        phase_reg <= ~phase_reg;
      end
      if (intermediate_clock_next) begin
        cnt16_reg <= cnt16_reg + 4'h1;
      end
      intermediate_clock_tick_o <= intermediate_clock_next;
      div16_tick_o <= intermediate_clock_next & (cnt16_reg == DIV16_LAST);
    end
  end
endmodule

/* rtl/lock_comparator.sv */
// frequency comparator between the intermediate strobe and the vco strobe
module lock_comparator
  import clock_unit_pkg::*;
#(
  parameter int WINDOW = LOCK_WINDOW_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic restart_i,
  input wire logic ref_tick_i,
  input wire logic vco_tick_i,
  input wire logic [4:0] mult_i,
  output logic lock_o
);

  localparam int CW = $clog2(WINDOW * 32 + 1);
  logic [CW-1:0] ref_cnt_reg, vco_cnt_reg;
  logic [1:0] good_reg;
  wire [CW-1:0] expect_cnt = CW'(WINDOW) * CW'(mult_i);
  wire window_end = ref_tick_i & (ref_cnt_reg == CW'(WINDOW - 1));
  wire [CW-1:0] vco_total = vco_cnt_reg + CW'(vco_tick_i);
  wire [CW-1:0] diff = (vco_total > expect_cnt) ?
    vco_total - expect_cnt : expect_cnt - vco_total;
  wire match = diff <= CW'(LOCK_TOL);

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i || restart_i) begin
      ref_cnt_reg <= '0;
      vco_cnt_reg <= '0;
      good_reg <= 2'h0;
      lock_o <= 1'b0;
    end else if (window_end) begin
      ref_cnt_reg <= '0;
      vco_cnt_reg <= '0;
      if (match && good_reg != 2'(LOCK_GOOD)) begin
        good_reg <= good_reg + 2'h1;
      end else if (!match) begin
        good_reg <= 2'h0;
      end
      // lock holds while windows keep matching, drops on any miss
      lock_o <= match && (good_reg >= 2'(LOCK_GOOD - 1));
    end else begin
      ref_cnt_reg <= ref_cnt_reg + CW'(ref_tick_i);
      vco_cnt_reg <= vco_total;
    end
  end
endmodule

/* rtl/clock_select_unit.sv */
// clock source selection, pll control, lock and event flags of the unit
//
// Added by the designer: the Wishbone slave port and the register addresses.
module clock_select_unit
  import clock_unit_pkg::*;
#(
  parameter int LOCK_WINDOW = LOCK_WINDOW_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_tick_i,
  input wire logic vco_tick_i,
  input wire logic free_run_tick_i,
  input wire logic alt_32k_tick_i,
  input wire logic regulator_ready_i,
  input wire logic stop_wake_i,
  output logic root_tick_o,
  output root_src_t root_src_o,
  output pll_mode_t pll_mode_o,
  output logic [4:0] pll_mult_o,
  output logic [2:0] pll_div_n_o,
  output logic [9:0] free_run_khz_o,
  output logic [15:0] main_div_o,
  output logic [15:0] periph_div_o,
  output logic irq_o
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [15:0] flag_reg, flag_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] pll_reg, pll_next;
  logic [15:0] mdiv_reg, pdiv_reg;
  logic [31:0] rdata_next;
  logic lock_prev_reg, not_slow_prev_reg, alt_prev_reg;
  logic [2:0] pll_cnt_reg;
  logic pll_tick_reg;
  logic [PLL_CFG_W-1:0] cfg_prev_reg;
  logic halve_prev_reg;
  logic lock_flag;
  logic intermediate_clock_tick, div16_tick;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire access = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  wire wr = access & wb_req_i.we;
  wire hit_flag = wb_req_i.adr == ADDR_FLAG;
  wire hit_ctrl = wb_req_i.adr == ADDR_CTRL;
  wire hit_pll = wb_req_i.adr == ADDR_PLL;
  wire hit_mdiv = wb_req_i.adr == ADDR_MDIV;
  wire hit_pdiv = wb_req_i.adr == ADDR_PDIV;
  wire [15:0] lane_mask = {{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  wire [15:0] wdata = wb_req_i.dat[15:0];

  // ****************************************************************
  // configuration decode
  // ****************************************************************
  pll_cfg_t cfg;
  assign cfg = pll_cfg_t'(pll_reg[PLL_CFG_W-1:0]);
  wire halve = flag_reg[FLAG_HALVE];
  wire not_slow = flag_reg[FLAG_NOT_SLOW];
  wire pll_sel = flag_reg[FLAG_PLL_SEL];
  wire alt_sel = ctrl_reg[CTRL_ALT_SEL];
  wire div_off = cfg.pll_divider_field == DIV_OFF_CODE;
  wire loop_on = ~div_off;
  wire free_on = div_off & cfg.free_run_enable;
  wire [2:0] div_n = cfg.pll_divider_field; // n - 1
  logic [4:0] mult_val;
  always_comb begin
    case (cfg.pll_multiplier_field)
      MULT_CODE_24: mult_val = MULT_24;
      MULT_CODE_20: mult_val = MULT_20;
      MULT_CODE_16: mult_val = MULT_16;
      MULT_CODE_12: mult_val = MULT_12;
      default: mult_val = MULT_20;
    endcase
  end
  // codes with a one in the low bit run at the slower rate
  wire slow_code = cfg.pll_multiplier_field[0];
  wire [9:0] free_khz = slow_code ?
    (cfg.reference_range_bit ? FREE_KHZ_250 : FREE_KHZ_125) :
    (cfg.reference_range_bit ? FREE_KHZ_500 : FREE_KHZ_250);
  wire [9:0] free_khz_next = free_on ? free_khz : 10'h000;
  pll_mode_t mode_next;
  assign mode_next = free_on ? PLL_FREE : (loop_on ? PLL_LOOP : PLL_OFF);

  // a change in multiplier, divider, mode or intermediate_clock restarts the comparator
  wire cfg_change = (pll_reg[PLL_CFG_W-1:0] != cfg_prev_reg) |
    (halve != halve_prev_reg);

  // ****************************************************************
  // intermediate clock and lock detection
  // ****************************************************************
  intermediate_divider u_intermediate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .osc_tick_i(osc_tick_i),
    .halve_i(halve),
    .intermediate_clock_tick_o(intermediate_clock_tick),
    .div16_tick_o(div16_tick)
  );

  lock_comparator #(
    .WINDOW(LOCK_WINDOW)
  ) u_lock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(loop_on),
    .restart_i(cfg_change),
    .ref_tick_i(intermediate_clock_tick),
    .vco_tick_i(vco_tick_i),
    .mult_i(mult_val),
    .lock_o(lock_flag)
  );

  // output divider: one pll strobe per n vco strobes; none when off
  wire pll_wrap = pll_cnt_reg >= div_n;
  wire pll_tick_next = loop_on & vco_tick_i & pll_wrap;

  // ****************************************************************
  // root source selection
  // ****************************************************************
  root_src_t src_next;
  always_comb begin
    if (alt_sel) begin
      src_next = SRC_ALT;
    end else if (!not_slow) begin
      src_next = SRC_DIV16;
    end else if (pll_sel && free_on) begin
      src_next = SRC_FREE_RUN;
    end else if (pll_sel && loop_on && lock_flag && regulator_ready_i) begin
      src_next = SRC_PLL;
    end else begin
      src_next = SRC_INTERMEDIATE;
    end
  end

  logic root_tick_next;
  always_comb begin
    case (src_next)
      SRC_ALT: root_tick_next = alt_32k_tick_i;
      SRC_DIV16: root_tick_next = div16_tick;
      SRC_FREE_RUN: root_tick_next = free_run_tick_i;
      SRC_PLL: root_tick_next = pll_tick_reg;
      SRC_INTERMEDIATE: root_tick_next = intermediate_clock_tick;
      default: root_tick_next = intermediate_clock_tick;
    endcase
  end

  // ****************************************************************
  // events
  // ****************************************************************
  wire ev_alt = alt_sel ^ alt_prev_reg;
  wire ev_div16 = not_slow ^ not_slow_prev_reg;
  wire ev_lock = lock_flag ^ lock_prev_reg;
  wire ev_stop = stop_wake_i;
  wire flag_clr = wr & hit_flag & wb_req_i.sel[0];
  wire [15:0] clr_bits = flag_clr ? wdata : 16'h0000;

  // ****************************************************************
  // register next values
  // ****************************************************************
  always_comb begin
    flag_next = flag_reg;
    if (wr && hit_flag) begin
      flag_next[FLAG_HALVE] = wb_req_i.sel[1] ? wdata[FLAG_HALVE] : halve;
      if (wb_req_i.sel[0]) begin
        flag_next[FLAG_PLL_SEL] = wdata[FLAG_PLL_SEL];
        flag_next[FLAG_NOT_SLOW] = wdata[FLAG_NOT_SLOW];
      end
    end
    flag_next[FLAG_LOCK] = lock_flag;
    // set wins over a clear in the same cycle; zero writes keep flags
    flag_next[FLAG_ALT_PEND] = ev_alt |
      (flag_reg[FLAG_ALT_PEND] & ~clr_bits[FLAG_ALT_PEND]);
    flag_next[FLAG_DIV16_PEND] = ev_div16 |
      (flag_reg[FLAG_DIV16_PEND] & ~clr_bits[FLAG_DIV16_PEND]);
    flag_next[FLAG_LOCK_PEND] = ev_lock |
      (flag_reg[FLAG_LOCK_PEND] & ~clr_bits[FLAG_LOCK_PEND]);
    flag_next[FLAG_STOP_PEND] = ev_stop |
      (flag_reg[FLAG_STOP_PEND] & ~clr_bits[FLAG_STOP_PEND]);
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    pll_next = pll_reg;
    if (wr && hit_ctrl) begin
      ctrl_next = (ctrl_reg & ~lane_mask) | (wdata & lane_mask);
      ctrl_next[15:4] = 12'h000;
    end
    // a free-run change while the pll drives root is not guarded
    if (wr && hit_pll) begin
      pll_next = (pll_reg & ~lane_mask) | (wdata & lane_mask);
      pll_next[15:PLL_CFG_W] = '0;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_flag) begin
      rdata_next[15:0] = flag_reg;
    end else if (hit_ctrl) begin
      rdata_next[15:0] = ctrl_reg;
    end else if (hit_pll) begin
      rdata_next[15:0] = pll_reg;
    end else if (hit_mdiv) begin
      rdata_next[15:0] = mdiv_reg;
    end else if (hit_pdiv) begin
      rdata_next[15:0] = pdiv_reg;
    end
  end

  // the alt event uses the lock mask CTRL_LOCK_IE, the same mask that gates lock events
  wire irq_next =
    (flag_reg[FLAG_ALT_PEND] & ctrl_reg[CTRL_LOCK_IE]) |
    (flag_reg[FLAG_DIV16_PEND] & ctrl_reg[CTRL_DIV16_IE]) |
    (flag_reg[FLAG_LOCK_PEND] & ctrl_reg[CTRL_LOCK_IE]) |
    (flag_reg[FLAG_STOP_PEND] & ctrl_reg[CTRL_STOP_IE]);

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= FLAG_RESET;
      ctrl_reg <= CTRL_RESET;
      pll_reg <= PLL_RESET;
      mdiv_reg <= FACT_RESET;
      pdiv_reg <= FACT_RESET;
    end else begin
      flag_reg <= flag_next;
      ctrl_reg <= ctrl_next;
      pll_reg <= pll_next;
      if (wr && hit_mdiv) begin
        mdiv_reg <= (mdiv_reg & ~lane_mask) | (wdata & lane_mask);
      end
      if (wr && hit_pdiv) begin
        pdiv_reg <= (pdiv_reg & ~lane_mask) | (wdata & lane_mask);
      end
    end
  end

  // ack gates access, so a request held by the master is taken again every other cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (access && !wb_req_i.we) begin
        wb_dat_o <= rdata_next;
      end
    end
  end

  // history starts at the reset state so release gives no false event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_prev_reg <= 1'b0;
      not_slow_prev_reg <= FLAG_RESET[FLAG_NOT_SLOW];
      alt_prev_reg <= CTRL_RESET[CTRL_ALT_SEL];
      halve_prev_reg <= FLAG_RESET[FLAG_HALVE];
      cfg_prev_reg <= PLL_RESET[PLL_CFG_W-1:0];
    end else begin
      lock_prev_reg <= lock_flag;
      not_slow_prev_reg <= not_slow;
      alt_prev_reg <= alt_sel;
      halve_prev_reg <= halve;
      cfg_prev_reg <= pll_reg[PLL_CFG_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_cnt_reg <= 3'h0;
      pll_tick_reg <= 1'b0;
    end else begin
      if (!loop_on || cfg_change) begin
        pll_cnt_reg <= 3'h0;
      end else if (vco_tick_i) begin
        pll_cnt_reg <= pll_wrap ? 3'h0 : pll_cnt_reg + 3'h1;
      end
      pll_tick_reg <= pll_tick_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      root_tick_o <= 1'b0;
      root_src_o <= SRC_INTERMEDIATE;
      pll_mode_o <= PLL_OFF;
      pll_mult_o <= MULT_20;
      pll_div_n_o <= DIV_OFF_CODE;
      free_run_khz_o <= 10'h000;
    end else begin
      root_tick_o <= root_tick_next;
      root_src_o <= src_next;
      pll_mode_o <= mode_next;
      pll_mult_o <= mult_val;
      pll_div_n_o <= div_n;
      free_run_khz_o <= free_khz_next;
    end
  end

  // every output leaves a flop, so decode ripple never reaches a pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_div_o <= FACT_RESET;
      periph_div_o <= FACT_RESET;
      irq_o <= 1'b0;
    end else begin
      main_div_o <= mdiv_reg;
      periph_div_o <= pdiv_reg;
      irq_o <= irq_next;
    end
  end

endmodule

/* test/clock_select_unit_asserts.sv */
// port checker of the clock select unit
module clock_select_unit_asserts
  import clock_unit_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wb_req_t wb_req_i,
  input wire logic wb_ack_o,
  input wire logic regulator_ready_i,
  input wire root_src_t root_src_o,
  input wire pll_mode_t pll_mode_o,
  input wire logic [4:0] pll_mult_o,
  input wire logic [2:0] pll_div_n_o,
  input wire logic [9:0] free_run_khz_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // helper logic
  // ****************
  logic wr_taken;
  logic pll_wr;
  logic wr_q;
  logic [6:0] cfg_q;
  assign wr_taken = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~wb_ack_o;
  assign pll_wr = wr_taken & (wb_req_i.adr == ADDR_PLL) & wb_req_i.sel[0];
  // keeps the last pll config so later cycles can be compared with it
  always_ff @(posedge clk_i) begin
    wr_q <= wr_taken & ~rst_i;
    if (pll_wr) begin
      cfg_q <= wb_req_i.dat[6:0];
    end
  end
  function automatic logic [4:0] mult_of(input logic [1:0] c);
    return c[0] ? (c[1] ? 5'h10 : 5'h0c) : (c[1] ? 5'h18 : 5'h14);
  endfunction
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************
  // assertions
  // ****************
  a_ack_follows: assert property (
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse after request");
  a_mult_code: assert property (
    pll_wr && wb_req_i.dat[4:2] != 3'h7 |->
      ##[2:3] pll_mult_o == mult_of(cfg_q[1:0]))
    else $error("multiply factor does not follow code");
  a_div_field: assert property (
    pll_wr |-> ##[2:3] pll_div_n_o == cfg_q[4:2])
    else $error("divider field not reflected");
  a_off_mode: assert property (
    pll_mode_o == PLL_OFF |-> pll_div_n_o == DIV_OFF_CODE)
    else $error("pll off without divider code 7");
  a_free_rate: assert property (
    pll_mode_o == PLL_FREE |-> pll_div_n_o == 3'h7 &&
      (pll_mult_o inside {5'h0c, 5'h10}
      ? free_run_khz_o inside {10'h07d, 10'h0fa}
      : free_run_khz_o inside {10'h0fa, 10'h1f4}))
    else $error("free run rate wrong");
  a_free_zero: assert property (
    pll_mode_o != PLL_FREE |-> free_run_khz_o == 10'h000)
    else $error("free run rate outside free mode");
  a_pll_gate: assert property (
    root_src_o == SRC_PLL |-> $past(pll_mode_o) == PLL_LOOP)
    else $error("pll root without closed loop");
  a_free_src: assert property (
    root_src_o == SRC_FREE_RUN |-> $past(pll_mode_o) == PLL_FREE)
    else $error("free run root without free mode");
  a_reg_gate: assert property (
    !regulator_ready_i [*3] |-> root_src_o != SRC_PLL)
    else $error("pll root while regulator not ready");
  a_unlock_fall: assert property (
    pll_wr |-> ##[1:3] root_src_o != SRC_PLL)
    else $error("pll root kept after config change");
  a_irq_hold: assert property (
    irq_o && !wr_taken && !wr_q |=> irq_o)
    else $error("irq dropped without a write");
  c_pll_root: cover property (root_src_o == SRC_PLL);
  c_free_root: cover property (root_src_o == SRC_FREE_RUN);
  c_irq: cover property ($rose(irq_o));
endmodule

bind clock_select_unit clock_select_unit_asserts chk_i (
  .clk_i, .rst_i, .wb_req_i, .wb_ack_o, .regulator_ready_i, .root_src_o,
  .pll_mode_o, .pll_mult_o, .pll_div_n_o, .free_run_khz_o, .irq_o
);

/* test/osc_side_model.sv */
// oscillator side model: input, vco, back-up and 32 kHz strobes
module osc_side_model
  import clock_unit_pkg::*;
#(
  parameter int OSC_PERIOD = 32,
  parameter int FREE_PERIOD = 40,
  parameter int ALT_PERIOD = 100
) (
  input wire logic clk_i,
  input wire logic halve_i,
  input wire pll_mode_t pll_mode_i,
  input wire logic [4:0] pll_mult_i,
  output logic osc_tick_o = 1'b0,
  output logic vco_tick_o = 1'b0,
  output logic free_run_tick_o = 1'b0,
  output logic alt_32k_tick_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int osc_cnt = 0;
  int free_cnt = 0;
  int alt_cnt = 0;
  int burst = 0;
  // vco strobes come as a burst after each oscillator strobe, so each
  // intermediate period holds exactly the multiplied count; the vco is
  // silent unless the loop is closed
  always @(posedge clk_i) begin
    osc_cnt <= (osc_cnt + 1) % OSC_PERIOD;
    free_cnt <= (free_cnt + 1) % FREE_PERIOD;
    alt_cnt <= (alt_cnt + 1) % ALT_PERIOD;
    osc_tick_o <= osc_cnt == 0;
    free_run_tick_o <= free_cnt == 0;
    alt_32k_tick_o <= alt_cnt == 0;
    if (osc_cnt == 0) begin
      burst <= int'(halve_i ? pll_mult_i >> 1 : pll_mult_i);
    end else if (burst > 0) begin
      burst <= burst - 1;
    end
    vco_tick_o <= pll_mode_i == PLL_LOOP && burst > 0;
  end
endmodule

/* test/clock_select_unit_tb_top.sv */
// self-checking bench of the clock select unit
module clock_select_unit_tb_top
  import clock_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic osc_tick, vco_tick, free_tick, alt_tick;
  logic ready = 1'b0;
  logic stop_wake = 1'b0;
  logic halve = 1'b1;
  logic root_tick_o;
  root_src_t root_src_o;
  pll_mode_t pll_mode_o;
  logic [4:0] pll_mult_o;
  logic [2:0] pll_div_n_o;
  logic [9:0] free_run_khz_o;
  logic [15:0] main_div_o, periph_div_o;
  logic irq_o;
  logic [31:0] rd;
  logic [4:0] mtab [4] = '{5'h14, 5'h0c, 5'h18, 5'h10};
  int bad_count = 0;
  int checks = 0;
  int n;
  always #12.5 clk_i = ~clk_i;
  clock_select_unit #(.LOCK_WINDOW(8)) uut (
    .clk_i, .rst_i, .wb_req_i(req), .wb_dat_o, .wb_ack_o,
    .osc_tick_i(osc_tick), .vco_tick_i(vco_tick),
    .free_run_tick_i(free_tick), .alt_32k_tick_i(alt_tick),
    .regulator_ready_i(ready), .stop_wake_i(stop_wake), .root_tick_o,
    .root_src_o, .pll_mode_o, .pll_mult_o, .pll_div_n_o, .free_run_khz_o,
    .main_div_o, .periph_div_o, .irq_o
  );
  osc_side_model partner (
    .clk_i, .halve_i(halve), .pll_mode_i(pll_mode_o),
    .pll_mult_i(pll_mult_o), .osc_tick_o(osc_tick), .vco_tick_o(vco_tick),
    .free_run_tick_o(free_tick), .alt_32k_tick_o(alt_tick)
  );
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h3, dat: d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) bad_count++;
    rd = wb_dat_o;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, {16'h0000, d});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, {16'h0000, e});
  endtask
  task automatic srcchk(input root_src_t e);
    repeat (4) @(posedge clk_i);
    chk(32'(root_src_o), 32'(e));
  endtask
  task automatic ticks(input int span, input int e);
    int c = 0;
    repeat (span) begin
      @(posedge clk_i);
      if (root_tick_o === 1'b1) c++;
    end
    chk(c, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(ADDR_FLAG, 16'h8008);
    rdchk(ADDR_CTRL, 16'h0000);
    rdchk(ADDR_PLL, 16'h001c);
    rdchk(ADDR_MDIV, 16'h0000);
    rdchk(ADDR_PDIV, 16'h0000);
    rdchk(8'h20, 16'h0000);
    srcchk(SRC_INTERMEDIATE);
    wr(ADDR_MDIV, 16'h1234);
    rdchk(ADDR_MDIV, 16'h1234);
    chk(main_div_o, 16'h1234);
    wr(ADDR_PDIV, 16'h5a0f);
    rdchk(ADDR_PDIV, 16'h5a0f);
    chk(periph_div_o, 16'h5a0f);
    $display("test reset done");
    ticks(640, 10);
    wr(ADDR_FLAG, 16'h0008);
    halve <= 1'b0;
    repeat (70) @(posedge clk_i);
    ticks(640, 20);
    wr(ADDR_FLAG, 16'h8008);
    halve <= 1'b1;
    $display("test halving done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PLL, 16'(i * 5));
      repeat (3) @(posedge clk_i);
      chk(pll_mult_o, mtab[i]);
      chk(pll_div_n_o, 3'(i));
    end
    $display("test codes done");
    wr(ADDR_PLL, 16'h0001);
    n = 0;
    do begin
      bus(1'b0, ADDR_FLAG, 32'h0000_0000);
      n++;
    end while (rd[FLAG_LOCK] !== 1'b1 && n < 1000);
    rdchk(ADDR_FLAG, 16'h802a);
    wr(ADDR_FLAG, 16'h8009);
    srcchk(SRC_INTERMEDIATE);
    ready <= 1'b1;
    srcchk(SRC_PLL);
    ticks(512, 96);
    rdchk(ADDR_FLAG, 16'h802b);
    wr(ADDR_FLAG, 16'h8029);
    rdchk(ADDR_FLAG, 16'h800b);
    wr(ADDR_PLL, 16'h0003);
    srcchk(SRC_INTERMEDIATE);
    rdchk(ADDR_FLAG, 16'h8029);
    wr(ADDR_FLAG, 16'h8028);
    $display("test lock done");
    ready <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_PLL, {9'h000, k[2], 1'b1, 3'h7, k[1:0]});
      repeat (3) @(posedge clk_i);
      chk(free_run_khz_o, (k[0] ? 10'h07d : 10'h0fa) << k[2]);
      chk(32'(pll_mode_o), 32'(PLL_FREE));
    end
    wr(ADDR_FLAG, 16'h8009);
    srcchk(SRC_FREE_RUN);
    ticks(400, 10);
    wr(ADDR_FLAG, 16'h8008);
    wr(ADDR_PLL, 16'h001c);
    srcchk(SRC_INTERMEDIATE);
    chk(32'(pll_mode_o), 32'(PLL_OFF));
    $display("test free run done");
    wr(ADDR_CTRL, 16'h0004);
    stop_wake <= 1'b1;
    @(posedge clk_i);
    stop_wake <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b1);
    rdchk(ADDR_FLAG, 16'h8048);
    wr(ADDR_CTRL, 16'h0000);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b0);
    wr(ADDR_CTRL, 16'h0004);
    wr(ADDR_FLAG, 16'h8048);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b0);
    wr(ADDR_CTRL, 16'h0002);
    wr(ADDR_FLAG, 16'h8000);
    srcchk(SRC_DIV16);
    chk(irq_o, 1'b1);
    ticks(2048, 2);
    wr(ADDR_CTRL, 16'h0008);
    srcchk(SRC_ALT);
    ticks(1000, 10);
    rdchk(ADDR_FLAG, 16'h8090);
    $display("test events done");
    tally_and_finish();
  end
endmodule
